/* rtl/bkpt_dbg_regs.vh */
// Operation
// R1: The device holds a breakpoint address in debug registers that the emulator loads by commands on the debug clock and data pins.
// R2: When told to run in debug mode the device starts at its reset vector and runs until the program counter equals the breakpoint address.
// R3: The breakpoint fires only after the instruction at the breakpoint address has executed, then control passes to the debug executive like an interrupt.
// R4: Once halted the debug executive exchanges breakpoint status and answers queries for file registers and processor state over the debug pins.
// R5: The debug executive runs from program memory like ordinary code and uses stack locations for its temporaries.
// R6: The emulator forces a halt by toggling the debug clock and data pins and the device then switches to the debug executive.
// R7: Debug communication needs the device to be executing, so with no running core the executive cannot answer.
// R8: Programming over the serial link needs no core clock and every configuration mode is programmable.
// R9: The programmer may place a program executive in high program memory to speed programming.
// R10: In programming or release mode the debug registers and all debug features stay disabled.
// R11: In release mode the emulator controls the device only by pulsing the master clear reset line; CMD_RUN still pulses core_restart in release mode.
// R12: During programming the emulator applies the programming level, clocks the clock pin and shifts data on the data pin, reading back to verify.
// R13: The device compares the program counter with the breakpoint address every instruction cycle in debug mode and raises a halt request on a match;
// the code makes no compare while halted is set.
`ifndef BKPT_DBG_REGS_VH
`define BKPT_DBG_REGS_VH
// link commands, 4 bit opcode then payload, msb first
`define CMD_W 4
`define CMD_LOAD_BKPT 4'h1
`define CMD_RUN 4'h2
`define CMD_READ_STAT 4'h3
`define CMD_READ_PC 4'h4
`define CMD_CFG_DEBUG 4'h5
`define CMD_CFG_RELEASE 4'h6
`define CMD_READ_FILE 4'h7
// halt toggle: data edges while clock high, count to force halt
`define HALT_TOGGLES 3'h4
// status bits
`define STAT_HALTED 0
`define STAT_BKPT_HIT 1
`define STAT_FORCED 2
`define STAT_DEBUG_EN 3
`endif

/* rtl/bkpt_dbg_link.v */
`timescale 1ns/1ps
`include "bkpt_dbg_regs.vh"
module bkpt_dbg_link #(
  parameter AW = 16,
  parameter DW = 8,
  parameter [AW-1:0] RESET_VECTOR = 16'h0000,
  parameter [AW-1:0] EXEC_VECTOR = 16'hF000
)(
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // debug link pins
  input wire debug_clock_pin,
  input wire debug_data_in,
  output reg debug_data_out,
  output reg debug_data_oe,
  // core side
  input wire core_running,
  input wire instr_done,
  input wire [AW-1:0] core_pc,
  input wire [DW-1:0] core_status,
  input wire [DW-1:0] file_rdata,
  output reg [AW-1:0] file_addr,
  output reg core_restart,
  output reg [AW-1:0] restart_vector,
  output reg halt_req,
  output reg [AW-1:0] halt_vector,
  input wire exec_resume,
  // mode
  output reg debug_enable,
  output reg halted
);
  localparam ST_CMD = 2'd0;
  localparam ST_ARG = 2'd1;
  localparam ST_OUT = 2'd2;
  localparam SW = AW + 4;
  // two flop synchronisers on link pins
  reg clk_m_q, clk_s_q, clk_p_q;
  reg dat_m_q, dat_s_q, dat_p_q;
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_m_q <= 1'b0;
      clk_s_q <= 1'b0;
      clk_p_q <= 1'b0;
      dat_m_q <= 1'b0;
      dat_s_q <= 1'b0;
      dat_p_q <= 1'b0;
    end
    else
    begin
      clk_m_q <= debug_clock_pin;
      clk_s_q <= clk_m_q;
      clk_p_q <= clk_s_q;
      dat_m_q <= debug_data_in;
      dat_s_q <= dat_m_q;
      dat_p_q <= dat_s_q;
    end
  end
  wire clk_rise = clk_s_q & ~clk_p_q;
  wire clk_fall = ~clk_s_q & clk_p_q;
  // data toggling while clock stays high is outside normal framing
  wire dat_edge = clk_s_q & clk_p_q & (dat_s_q ^ dat_p_q);
  reg [1:0] st_q;
  reg [AW-1:0] shift_q;
  reg [5:0] cnt_q;
  reg [`CMD_W-1:0] cmd_q;
  reg [AW-1:0] bkpt_q;
  reg [2:0] tog_q;
  reg hit_q, forced_q;
  reg [SW-1:0] out_q;
  wire match = debug_enable & ~halted & instr_done & (core_pc == bkpt_q);
  wire force_hit = debug_enable & ~halted & (tog_q == `HALT_TOGGLES);
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= ST_CMD;
      shift_q <= {AW{1'b0}};
      cnt_q <= 6'd0;
      cmd_q <= {`CMD_W{1'b0}};
      bkpt_q <= {AW{1'b0}};
      tog_q <= 3'd0;
      hit_q <= 1'b0;
      forced_q <= 1'b0;
      out_q <= {SW{1'b0}};
      debug_data_out <= 1'b0;
      debug_data_oe <= 1'b0;
      file_addr <= {AW{1'b0}};
      core_restart <= 1'b0;
      restart_vector <= RESET_VECTOR;
      halt_req <= 1'b0;
      halt_vector <= EXEC_VECTOR;
      debug_enable <= 1'b0;
      halted <= 1'b0;
    end
    else
    begin
      core_restart <= 1'b0;
      halt_req <= 1'b0;
      if (clk_rise)
        tog_q <= 3'd0;
      else if (dat_edge && tog_q != `HALT_TOGGLES)
        tog_q <= tog_q + 3'd1;
      // fires after the matching instruction retires
      // a halt pattern leaves stray framing bits, so restart command framing
      if (tog_q == `HALT_TOGGLES)
      begin
        st_q <= ST_CMD;
        cnt_q <= 6'd0;
      end
      if (match || force_hit) // R3 R6 R13
      begin
        halt_req <= 1'b1;
        halt_vector <= EXEC_VECTOR; // R5
        halted <= 1'b1;
        hit_q <= match;
        forced_q <= force_hit & ~match;
        tog_q <= 3'd0;
      end
      else if (exec_resume)
        halted <= 1'b0;
      if (clk_fall && st_q == ST_OUT)
      begin
        debug_data_out <= out_q[SW-1];
        out_q <= {out_q[SW-2:0], 1'b0};
        cnt_q <= cnt_q - 6'd1;
        if (cnt_q == 6'd1)
        begin
          // release the pin before the next command bit is sampled
          st_q <= ST_CMD;
          cnt_q <= 6'd0;
          debug_data_oe <= 1'b0;
        end
      end
      if (clk_rise)
      begin
        case (st_q)
          ST_CMD:
          begin
            debug_data_oe <= 1'b0;
            cmd_q <= {cmd_q[`CMD_W-2:0], dat_s_q};
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q == `CMD_W - 1)
            begin
              cnt_q <= 6'd0;
              case ({cmd_q[`CMD_W-2:0], dat_s_q})
                `CMD_LOAD_BKPT, `CMD_READ_FILE: st_q <= ST_ARG;
                `CMD_RUN:
                begin
                  core_restart <= 1'b1; // R2
                  restart_vector <= RESET_VECTOR;
                  halted <= 1'b0;
                  hit_q <= 1'b0;
                  forced_q <= 1'b0;
                end
                `CMD_CFG_DEBUG: debug_enable <= 1'b1;
                `CMD_CFG_RELEASE:
                begin
                  debug_enable <= 1'b0; // R10
                  halted <= 1'b0;
                end
                `CMD_READ_STAT, `CMD_READ_PC:
                begin
                  // answers only while halted and core alive
                  if (debug_enable && halted && core_running) // R4 R7 R10
                  begin
                    st_q <= ST_OUT;
                    debug_data_oe <= 1'b1;
                    // one spare fall so the frame ends after the last clock
                    cnt_q <= 6'd21;
                    if ({cmd_q[`CMD_W-2:0], dat_s_q} == `CMD_READ_PC)
                      out_q <= {4'h0, core_pc};
                    else
                      out_q <= {{(SW-DW){1'b0}}, debug_enable, forced_q, hit_q, halted,
                                core_status[DW-5:0]};
                  end
                end
                default: st_q <= ST_CMD;
              endcase
            end
          end
          ST_ARG:
          begin
            shift_q <= {shift_q[AW-2:0], dat_s_q};
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q == AW - 1)
            begin
              cnt_q <= 6'd0;
              st_q <= ST_CMD;
              if (cmd_q == `CMD_LOAD_BKPT && debug_enable)
                bkpt_q <= {shift_q[AW-2:0], dat_s_q}; // R1 R8 R10
              else if (cmd_q == `CMD_READ_FILE && debug_enable && halted && core_running)
              begin
                file_addr <= {shift_q[AW-2:0], dat_s_q}; // R4
                st_q <= ST_OUT;
                debug_data_oe <= 1'b1;
                cnt_q <= 6'd10;
                out_q <= {1'b0, file_rdata, {(SW-DW-1){1'b0}}};
              end
            end
          end
          ST_OUT: st_q <= ST_OUT;
          default: st_q <= ST_CMD;
        endcase
      end
    end
  end
endmodule // bkpt_dbg_link

/* bench/bkpt_dbg_link_sva.sv */
`timescale 1ns/1ps
module bkpt_dbg_link_sva #(parameter AW = 16, parameter [AW-1:0] RV = 0)(
  // watched ports
  input wire ref_clk,
  input wire rst_b,
  input wire debug_data_oe,
  input wire core_running,
  input wire exec_resume,
  input wire core_restart,
  input wire [AW-1:0] restart_vector,
  input wire halt_req,
  input wire debug_enable,
  input wire halted
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_halt_flag_set: assert property (halt_req |-> ##[0:1] halted) else $error("no halt");
  a_halt_one_pulse: assert property (halt_req |=> !halt_req) else $error("halt long");
  a_halt_needs_en: assert property (halt_req |-> debug_enable) else $error("halt off");
  a_resume_clears: assert property (halted && exec_resume |=> !halted) else $error("stuck");
  a_read_when_halted: assert property (debug_data_oe |-> halted) else $error("oe run");
  a_read_needs_core: assert property ($rose(debug_data_oe) |-> core_running) else $error("oe");
  a_restart_pulse: assert property (core_restart |=> !core_restart) else $error("restart");
  a_restart_vec: assert property (core_restart |-> restart_vector == RV) else $error("vector");
endmodule // bkpt_dbg_link_sva
bind bkpt_dbg_link bkpt_dbg_link_sva #(.AW(AW), .RV(RESET_VECTOR)) u_sva (.ref_clk(ref_clk),
  .rst_b(rst_b), .debug_data_oe(debug_data_oe), .core_running(core_running),
  .exec_resume(exec_resume), .core_restart(core_restart), .restart_vector(restart_vector),
  .halt_req(halt_req), .debug_enable(debug_enable), .halted(halted));

/* bench/emu_pod.sv */
`timescale 1ns/1ps
module emu_pod (
  // link pins
  output logic clk_o,
  output logic data_o,
  input wire data_i
);
  initial clk_o = 0;
  initial data_o = 1;
  // clock stands low between frames
  task automatic xfer(input logic [19:0] v, input int n, output logic [19:0] r);
    r = 0;
    for (int i = n - 1; i >= 0; i--)
    begin
      data_o = v[i];
      #160 clk_o = 1;
      r = {r[18:0], data_i};
      #160 clk_o = 0;
    end
    #160;
  endtask
  task automatic force_halt();
    clk_o = 1;
    repeat (4) #160 data_o = ~data_o;
    #160 clk_o = 0;
    #640;
  endtask
endmodule // emu_pod

/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "bkpt_dbg_regs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module tb_top;
  logic ref_clk = 0, rst_b = 0, core_running = 1, instr_done = 0, exec_resume = 0;
  logic [15:0] core_pc = 0;
  logic [7:0] core_status = 8'hA5, file_rdata = 8'h3C;
  logic [19:0] r;
  wire link_clk, pod_data, data_out, data_oe, restart, hreq, dbg_en, halted;
  wire [15:0] file_addr;
  wire wire_level = data_oe ? data_out : pod_data;
  int fails = 0, tests_run = 0, n_halt = 0, n_restart = 0, n_oe = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    n_halt += hreq;
    n_restart += restart;
    n_oe += data_oe;
  end
  bkpt_dbg_link u_bkpt_dbg_link (.ref_clk(ref_clk), .rst_b(rst_b), .debug_clock_pin(link_clk),
    .debug_data_in(wire_level), .debug_data_out(data_out), .debug_data_oe(data_oe),
    .core_running(core_running), .instr_done(instr_done), .core_pc(core_pc),
    .core_status(core_status), .file_rdata(file_rdata), .file_addr(file_addr),
    .core_restart(restart), .restart_vector(), .halt_req(hreq), .halt_vector(),
    .exec_resume(exec_resume), .debug_enable(dbg_en), .halted(halted));
  emu_pod u_emu_pod (.clk_o(link_clk), .data_o(pod_data), .data_i(wire_level));
  task step(input logic [15:0] pc);
    @(posedge ref_clk) {instr_done, core_pc} <= {1'b1, pc};
    @(posedge ref_clk) instr_done <= 0;
    repeat (3) @(posedge ref_clk);
  endtask
  task t_release;
    u_emu_pod.xfer({`CMD_LOAD_BKPT, 16'h0123}, 20, r);
    step(16'h0123);
    `CHK(dbg_en, 1'b0)
    `CHK(n_halt, 0)
  endtask
  task t_bkpt;
    u_emu_pod.xfer(`CMD_CFG_DEBUG, 4, r);
    u_emu_pod.xfer({`CMD_LOAD_BKPT, 16'h0123}, 20, r);
    u_emu_pod.xfer(`CMD_RUN, 4, r);
    `CHK(dbg_en, 1'b1)
    `CHK(n_restart, 1)
    step(16'h0122);
    `CHK(n_halt, 0)
    step(16'h0123);
    `CHK(n_halt, 1)
    `CHK(halted, 1'b1)
  endtask
  task t_query;
    u_emu_pod.xfer(`CMD_READ_STAT, 4, r);
    u_emu_pod.xfer(0, 20, r);
    `CHK(r, 20'h000B5)
    @(posedge ref_clk) core_pc <= 16'h0456;
    u_emu_pod.xfer(`CMD_READ_PC, 4, r);
    u_emu_pod.xfer(0, 20, r);
    `CHK(r, 20'h00456)
    u_emu_pod.xfer({`CMD_READ_FILE, 16'h0042}, 20, r);
    u_emu_pod.xfer(0, 9, r);
    `CHK(r[8:0], 9'h03C)
    `CHK(file_addr, 16'h0042)
  endtask
  task t_force;
    int k;
    @(posedge ref_clk) exec_resume <= 1;
    @(posedge ref_clk) exec_resume <= 0;
    @(posedge ref_clk);
    `CHK(halted, 1'b0)
    u_emu_pod.force_halt();
    `CHK(n_halt, 2)
    `CHK(halted, 1'b1)
    // a stopped core cannot answer, so no read may start
    @(posedge ref_clk) core_running <= 0;
    k = n_oe;
    u_emu_pod.xfer(`CMD_READ_STAT, 4, r);
    u_emu_pod.xfer(0, 20, r);
    `CHK(n_oe, k)
    @(posedge ref_clk) core_running <= 1;
    u_emu_pod.xfer(`CMD_CFG_RELEASE, 4, r);
    `CHK(dbg_en, 1'b0)
    u_emu_pod.force_halt();
    `CHK(n_halt, 2)
    @(posedge ref_clk) rst_b <= 0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1;
    repeat (3) @(posedge ref_clk);
    `CHK(halted, 1'b0)
    `CHK(dbg_en, 1'b0)
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1;
    repeat (3) @(posedge ref_clk);
    t_release;
    t_bkpt;
    t_query;
    t_force;
    give_verdict;
  end
  initial
  begin
    #2000000;
    fails++;
    give_verdict;
  end
endmodule // tb_top
